// *** hw/pac_top.v ***
/*
 * pac_top.v: process alarm comparator with APB register access.
 * Assumes the sensor front end presents a converted value and fault pins
 * asynchronously; the value is sampled on the internal 5 Hz tick.
 */
// What this block does
// - two independent alarm channels, each with relay output and status indicator.
// - each channel selects off, sensor fault, low, high, diff low, diff high, band.
// - sensor fault function alarms on open sensor, out-of-range or shorted input.
// - low function alarms when the measured value is below the setpoint.
// - high function alarms when the measured value is above the setpoint.
// - differential functions use a reference and a signed deviation per channel.
// - band with positive deviation alarms outside reference plus/minus deviation.
// - band with negative deviation alarms inside reference plus/minus deviation.
// - differential low alarms below reference minus deviation.
// - differential high alarms above reference plus deviation.
// - a new value is taken five times a second and alarms re-evaluated.
// - values are signed integers from -1999 to 9999.
`timescale 1ns/1ps
`include "pac_defs.vh"
module pac_top #(
    parameter W             = `PAC_VAL_W,
    parameter SAMPLE_CYCLES = `PAC_SAMPLE_CYCLES,
    parameter [31:0] ID_VALUE = 32'h0000A5A5  // arbitrary value
) (
    // clock and reset
    input  wire         CLK,
    input  wire         RESET,
    // apb slave
    input  wire         PSEL,
    input  wire         PENABLE,
    input  wire         PWRITE,
    input  wire [11:0]  PADDR,
    input  wire [31:0]  PWDATA,
    output reg  [31:0]  PRDATA,
    output reg          PREADY,
    output reg          PSLVERR,
    // sensor front end
    input  wire [W-1:0] MEASURED_VALUE,
    input  wire         SENSOR_OPEN,
    input  wire         SENSOR_SHORT,
    input  wire         SIGNAL_OUT_OF_RANGE,
    // alarm outputs
    output reg          RELAY_ONE,
    output reg          RELAY_TWO,
    output reg          ALARM_INDICATOR_ONE,
    output reg          ALARM_INDICATOR_TWO,
    output reg          SAMPLE_TICK
);
    localparam CW = 25;

    // settings
    reg  [2:0]         fn1_reg;
    reg  [2:0]         fn2_reg;
    reg  signed [W-1:0] sp1_reg;
    reg  signed [W-1:0] dev1_reg;
    reg  signed [W-1:0] sp2_reg;
    reg  signed [W-1:0] dev2_reg;

    // sampled value
    reg  signed [W-1:0] value_reg;
    reg                fault_reg;
    reg                range_reg;
    reg  [7:0]         sample_cnt_reg;
    reg  [CW-1:0]      tick_cnt_reg;
    reg                eval_reg;

    // pin synchronisers
    wire [W-1:0] value_sync;
    wire         open_sync;
    wire         short_sync;
    wire         oor_sync;

    genvar gi;
    generate
        for (gi = 0; gi < W; gi = gi + 1) begin : g_vsync
            pac_sync u_sync (
                .CLK   (CLK),
                .RESET (RESET),
                .d     (MEASURED_VALUE[gi]),
                .q     (value_sync[gi])
            );
        end
    endgenerate

    pac_sync u_open  (.CLK(CLK), .RESET(RESET), .d(SENSOR_OPEN),         .q(open_sync));
    pac_sync u_short (.CLK(CLK), .RESET(RESET), .d(SENSOR_SHORT),        .q(short_sync));
    pac_sync u_oor   (.CLK(CLK), .RESET(RESET), .d(SIGNAL_OUT_OF_RANGE), .q(oor_sync));

    // range check of the incoming value
    wire signed [W-1:0] vs        = value_sync;
    wire signed [31:0]  vmin_full = `PAC_VAL_MIN;
    wire signed [31:0]  vmax_full = `PAC_VAL_MAX;
    wire signed [W-1:0] vmin      = vmin_full[W-1:0];
    wire signed [W-1:0] vmax      = vmax_full[W-1:0];
    wire                vs_range  = (vs < vmin) || (vs > vmax);
    wire signed [W-1:0] vs_clamp  = (vs < vmin) ? vmin : ((vs > vmax) ? vmax : vs);

    // 5 Hz sample tick
    wire tick = (tick_cnt_reg == SAMPLE_CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1});

    always @(posedge CLK) begin
        if (RESET) begin
            tick_cnt_reg   <= {CW{1'b0}};
            value_reg      <= `PAC_SETTING_RST;
            fault_reg      <= 1'b0;
            range_reg      <= 1'b0;
            sample_cnt_reg <= 8'h00;
            eval_reg       <= 1'b0;
        end else begin
            eval_reg <= tick;
            if (tick) begin
                tick_cnt_reg   <= {CW{1'b0}};
                value_reg      <= vs_clamp;
                range_reg      <= vs_range;
                fault_reg      <= open_sync | short_sync | oor_sync | vs_range;
                sample_cnt_reg <= sample_cnt_reg + 8'h01;
            end else begin
                tick_cnt_reg <= tick_cnt_reg + {{(CW-1){1'b0}}, 1'b1};
            end
        end
    end

    // channel evaluation
    wire alarm1;
    wire alarm2;

    pac_channel #(.W(W)) u_ch1 (
        .func      (fn1_reg),
        .setpoint  (sp1_reg),
        .deviation (dev1_reg),
        .value     (value_reg),
        .fault     (fault_reg),
        .alarm     (alarm1)
    );

    pac_channel #(.W(W)) u_ch2 (
        .func      (fn2_reg),
        .setpoint  (sp2_reg),
        .deviation (dev2_reg),
        .value     (value_reg),
        .fault     (fault_reg),
        .alarm     (alarm2)
    );

    // outputs update once per sample, the cycle after it is taken
    always @(posedge CLK) begin
        if (RESET) begin
            RELAY_ONE           <= 1'b0;
            RELAY_TWO           <= 1'b0;
            ALARM_INDICATOR_ONE <= 1'b0;
            ALARM_INDICATOR_TWO <= 1'b0;
            SAMPLE_TICK         <= 1'b0;
        end else begin
            SAMPLE_TICK <= eval_reg;
            if (eval_reg) begin
                RELAY_ONE           <= alarm1;
                ALARM_INDICATOR_ONE <= alarm1;
                RELAY_TWO           <= alarm2;
                ALARM_INDICATOR_TWO <= alarm2;
            end
        end
    end

    // apb access: two-cycle access phase, PREADY one cycle after PENABLE
    wire wr_en = PSEL & PENABLE & PWRITE & ~PREADY;
    wire rd_en = PSEL & PENABLE & ~PWRITE & ~PREADY;
    wire [11:0] a = {PADDR[11:2], 2'b00};

    wire mapped = (a == `PAC_CTRL_OFS) || (a == `PAC_STAT_OFS) || (a == `PAC_VALUE_OFS) ||
                  (a == `PAC_SP1_OFS)  || (a == `PAC_DEV1_OFS) || (a == `PAC_SP2_OFS)   ||
                  (a == `PAC_DEV2_OFS) || (a == `PAC_ID_OFS);

    // settings beyond the range are clamped, so setpoint and deviation stay within the indication range (sp +/- dev can still exceed it)
    wire signed [W-1:0] wv       = PWDATA[W-1:0];
    wire signed [W-1:0] wv_clamp = (wv < vmin) ? vmin : ((wv > vmax) ? vmax : wv);
    wire [2:0]          wfn1     = PWDATA[`PAC_CTRL_FN1_LSB +: `PAC_FN_W];
    wire [2:0]          wfn2     = PWDATA[`PAC_CTRL_FN2_LSB +: `PAC_FN_W];

    always @(posedge CLK) begin
        if (RESET) begin
            fn1_reg  <= `PAC_FN_OFF;
            fn2_reg  <= `PAC_FN_OFF;
            sp1_reg  <= `PAC_SETTING_RST;
            dev1_reg <= `PAC_SETTING_RST;
            sp2_reg  <= `PAC_SETTING_RST;
            dev2_reg <= `PAC_SETTING_RST;
        end else if (wr_en) begin
            case (a)
                `PAC_CTRL_OFS: begin
                    // unknown codes fall back to disabled
                    fn1_reg <= (wfn1 > `PAC_FN_BAND) ? `PAC_FN_OFF : wfn1;
                    fn2_reg <= (wfn2 > `PAC_FN_BAND) ? `PAC_FN_OFF : wfn2;
                end
                `PAC_SP1_OFS:  sp1_reg  <= wv_clamp;
                `PAC_DEV1_OFS: dev1_reg <= wv_clamp;
                `PAC_SP2_OFS:  sp2_reg  <= wv_clamp;
                `PAC_DEV2_OFS: dev2_reg <= wv_clamp;
                default: ;
            endcase
        end
    end

    reg [31:0] rdata;
    always @* begin
        rdata = 32'h00000000;
        case (a)
            `PAC_CTRL_OFS: begin
                rdata[`PAC_CTRL_FN1_LSB +: `PAC_FN_W] = fn1_reg;
                rdata[`PAC_CTRL_FN2_LSB +: `PAC_FN_W] = fn2_reg;
            end
            `PAC_STAT_OFS: begin
                rdata[`PAC_STAT_OUT1_BIT]        = RELAY_ONE;
                rdata[`PAC_STAT_OUT2_BIT]        = RELAY_TWO;
                rdata[`PAC_STAT_FAULT_BIT]       = fault_reg;
                rdata[`PAC_STAT_RANGE_BIT]       = range_reg;
                rdata[`PAC_STAT_CNT_LSB +: 8]    = sample_cnt_reg;
            end
            `PAC_VALUE_OFS: rdata = {{(32-W){value_reg[W-1]}}, value_reg};
            `PAC_SP1_OFS:   rdata = {{(32-W){sp1_reg[W-1]}}, sp1_reg};
            `PAC_DEV1_OFS:  rdata = {{(32-W){dev1_reg[W-1]}}, dev1_reg};
            `PAC_SP2_OFS:   rdata = {{(32-W){sp2_reg[W-1]}}, sp2_reg};
            `PAC_DEV2_OFS:  rdata = {{(32-W){dev2_reg[W-1]}}, dev2_reg};
            `PAC_ID_OFS:    rdata = ID_VALUE;
            default:        rdata = 32'h00000000;
        endcase
    end

    always @(posedge CLK) begin
        if (RESET) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h00000000;
        end else begin
            PREADY  <= wr_en | rd_en;
            PSLVERR <= (wr_en | rd_en) & ~mapped;
            if (rd_en)
                PRDATA <= mapped ? rdata : 32'h00000000;
        end
    end
endmodule // pac_top

// *** hw/pac_defs.vh ***
/*
 * pac_defs.vh: register offsets, field layouts, reset values, function codes
 * and timing counts for the process alarm comparator.
 * Assumes a 100 MHz system clock and a 32-bit APB register bus.
 */
`ifndef PAC_DEFS_VH
`define PAC_DEFS_VH

// register byte offsets
`define PAC_CTRL_OFS        12'h000
`define PAC_STAT_OFS        12'h004
`define PAC_VALUE_OFS       12'h008
`define PAC_SP1_OFS         12'h010
`define PAC_DEV1_OFS        12'h014
`define PAC_SP2_OFS         12'h018
`define PAC_DEV2_OFS        12'h01C
`define PAC_ID_OFS          12'h020

// control fields
`define PAC_CTRL_FN1_LSB    0
`define PAC_CTRL_FN2_LSB    4
`define PAC_FN_W            3

// status fields
`define PAC_STAT_OUT1_BIT   0
`define PAC_STAT_OUT2_BIT   1
`define PAC_STAT_FAULT_BIT  2
`define PAC_STAT_RANGE_BIT  3
`define PAC_STAT_CNT_LSB    8

// alarm function codes
`define PAC_FN_OFF          3'h0
`define PAC_FN_SENSOR       3'h1
`define PAC_FN_LOW          3'h2
`define PAC_FN_HIGH         3'h3
`define PAC_FN_DIFF_LOW     3'h4
`define PAC_FN_DIFF_HIGH    3'h5
`define PAC_FN_BAND         3'h6

// value range and reset values
`define PAC_VAL_W           16
`define PAC_VAL_MIN         (-1999)
`define PAC_VAL_MAX         9999
`define PAC_SETTING_RST     16'h0000
`define PAC_CTRL_RST        8'h00

// sample timing
`define PAC_CLK_HZ          100000000
`define PAC_SAMPLES_PER_S   5
`define PAC_SAMPLE_CYCLES   (`PAC_CLK_HZ / `PAC_SAMPLES_PER_S)

`endif

// *** hw/pac_sync.v ***
/*
 * pac_sync.v: two-flip-flop synchroniser for a single level.
 * Assumes the input may change at any time relative to CLK.
 */
`timescale 1ns/1ps
module pac_sync (
    // clock and reset
    input  wire CLK,
    input  wire RESET,
    // level
    input  wire d,
    output reg  q
);
    reg meta_reg;

    always @(posedge CLK) begin
        if (RESET) begin
            meta_reg <= 1'b0;
            q        <= 1'b0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule // pac_sync

// *** hw/pac_channel.v ***
/*
 * pac_channel.v: combinational evaluation of one alarm channel.
 * Assumes value, setpoint and deviation are held stable by the caller
 * and already limited to the indication range.
 */
`timescale 1ns/1ps
`include "pac_defs.vh"
module pac_channel #(
    parameter W = `PAC_VAL_W
) (
    // settings
    input  wire [2:0]         func,
    input  wire signed [W-1:0] setpoint,
    input  wire signed [W-1:0] deviation,
    // sample
    input  wire signed [W-1:0] value,
    input  wire               fault,
    // result
    output reg                alarm
);
    wire signed [W:0] v_ext  = {value[W-1], value};
    wire signed [W:0] lo_edge = {setpoint[W-1], setpoint} - {deviation[W-1], deviation};
    wire signed [W:0] hi_edge = {setpoint[W-1], setpoint} + {deviation[W-1], deviation};
    wire signed [W:0] sp_ext = {setpoint[W-1], setpoint};
    wire              dev_neg = deviation[W-1];
    // band spans min..max of the two edges, whichever sign the deviation has
    wire signed [W:0] band_lo = dev_neg ? hi_edge : lo_edge;
    wire signed [W:0] band_hi = dev_neg ? lo_edge : hi_edge;
    wire              outside = (v_ext < band_lo) || (v_ext > band_hi);

    always @* begin
        case (func)
            `PAC_FN_OFF:       alarm = 1'b0;
            `PAC_FN_SENSOR:    alarm = fault;
            `PAC_FN_LOW:       alarm = !fault && (v_ext < sp_ext);
            `PAC_FN_HIGH:      alarm = !fault && (v_ext > sp_ext);
            `PAC_FN_DIFF_LOW:  alarm = !fault && (v_ext < lo_edge);
            `PAC_FN_DIFF_HIGH: alarm = !fault && (v_ext > hi_edge);
            `PAC_FN_BAND: begin
                if (dev_neg)
                    alarm = !fault && !outside && (v_ext != band_lo) && (v_ext != band_hi);
                else
                    alarm = !fault && outside;
            end
            default:           alarm = 1'b0;
        endcase
    end
endmodule // pac_channel

// *** dv/pac_props_properties.sv ***
/* pac_props_properties.sv: port assertions for the alarm comparator.
   Assumes one CLK domain, RESET synchronous and active high. */
`timescale 1ns/1ps
module pac_props #(
    parameter SAMPLE_CYCLES = 20
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RESET,
    // apb
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // alarms
    input wire logic RELAY_ONE,
    input wire logic RELAY_TWO,
    input wire logic ALARM_INDICATOR_ONE,
    input wire logic ALARM_INDICATOR_TWO,
    input wire logic SAMPLE_TICK
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    logic [31:0] cnt_reg;
    logic        seen_reg;
    // cycles since the last sample tick
    always @(posedge CLK) begin
        if (RESET) begin
            cnt_reg  <= 32'h0;
            seen_reg <= 1'b0;
        end else if (SAMPLE_TICK) begin
            cnt_reg  <= 32'h0;
            seen_reg <= 1'b1;
        end else begin
            cnt_reg  <= cnt_reg + 32'h1;
        end
    end
    property p_ind_one; ALARM_INDICATOR_ONE == RELAY_ONE; endproperty
    property p_ind_two; ALARM_INDICATOR_TWO == RELAY_TWO; endproperty
    property p_relay_at_tick; !SAMPLE_TICK |-> $stable(RELAY_ONE) && $stable(RELAY_TWO); endproperty
    property p_tick_period; SAMPLE_TICK && seen_reg |-> cnt_reg == SAMPLE_CYCLES - 1; endproperty
    property p_tick_pulse; SAMPLE_TICK |=> !SAMPLE_TICK [*8]; endproperty
    property p_apb_answer; PSEL && PENABLE && !PREADY |=> PREADY; endproperty
    property p_apb_pulse; PREADY |=> !PREADY; endproperty
    property p_err_with_ready; PSLVERR |-> PREADY; endproperty
    a_ind_one: assert property (p_ind_one) else $error("indicator one differs from relay one");
    a_ind_two: assert property (p_ind_two) else $error("indicator two differs from relay two");
    a_relay_at_tick: assert property (p_relay_at_tick) else $error("relay moved off tick");
    a_tick_period: assert property (p_tick_period) else $error("sample tick spacing wrong");
    a_tick_pulse: assert property (p_tick_pulse) else $error("sample tick too long");
    a_apb_answer: assert property (p_apb_answer) else $error("no ready after access");
    a_apb_pulse: assert property (p_apb_pulse) else $error("ready longer than a cycle");
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
    c_relay_one: cover property ($rose(RELAY_ONE));
    c_relay_two: cover property ($rose(RELAY_TWO));
    c_slverr: cover property (PSLVERR);
endmodule // pac_props
bind pac_top pac_props #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) i_pac_props (.CLK(CLK), .RESET(RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PREADY(PREADY), .PSLVERR(PSLVERR), .RELAY_ONE(RELAY_ONE), .RELAY_TWO(RELAY_TWO),
    .ALARM_INDICATOR_ONE(ALARM_INDICATOR_ONE), .ALARM_INDICATOR_TWO(ALARM_INDICATOR_TWO),
    .SAMPLE_TICK(SAMPLE_TICK));

// *** dv/pac_sensor_model.sv ***
/* pac_sensor_model.sv: sensor front end driving value and fault pins.
   Assumes pins may only move right after a published sample. */
`timescale 1ns/1ps
module pac_sensor_model (
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // request from bench
    input  wire logic [15:0] want_value,
    input  wire logic [2:0]  want_fault,
    input  wire logic        SAMPLE_TICK,
    // pins
    output logic [15:0]      MEASURED_VALUE,
    output logic             SENSOR_OPEN,
    output logic             SENSOR_SHORT,
    output logic             SIGNAL_OUT_OF_RANGE
);
    // move pins far from the next capture; reset loads the requested idle levels
    always @(posedge CLK) begin
        if (RESET || SAMPLE_TICK) begin
            MEASURED_VALUE <= want_value;
            {SIGNAL_OUT_OF_RANGE, SENSOR_SHORT, SENSOR_OPEN} <= want_fault;
        end
    end
endmodule // pac_sensor_model

// *** dv/tb_pac_top.sv ***
/* tb_pac_top.sv: register and alarm function tests for pac_top.
   Assumes SAMPLE_CYCLES shortened to 20 and the sensor model on the pins. */
`timescale 1ns/1ps
`include "pac_defs.vh"
module tb_pac_top;
    localparam [31:0] ID_EXP = 32'h00003C3C;  // arbitrary value
    logic CLK = 0, RESET = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, rd;
    logic [15:0] want_value = 16'h0, mv;
    logic [2:0]  want_fault = 3'h0;
    logic rerr, so, ss, sr, prdy, perr, r1, r2, i1, i2, tick;
    logic [31:0] prd;
    int err_count = 0, tests_run = 0, cyc = 0;
    always #5 CLK = ~CLK;
    pac_sensor_model i_pac_sensor_model (.CLK(CLK), .RESET(RESET), .want_value(want_value),
        .want_fault(want_fault), .SAMPLE_TICK(tick), .MEASURED_VALUE(mv), .SENSOR_OPEN(so),
        .SENSOR_SHORT(ss), .SIGNAL_OUT_OF_RANGE(sr));
    pac_top #(.SAMPLE_CYCLES(20), .ID_VALUE(ID_EXP)) i_pac_top (.CLK(CLK), .RESET(RESET), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prd), .PREADY(prdy),
        .PSLVERR(perr), .MEASURED_VALUE(mv), .SENSOR_OPEN(so), .SENSOR_SHORT(ss), .SIGNAL_OUT_OF_RANGE(sr),
        .RELAY_ONE(r1), .RELAY_TWO(r2), .ALARM_INDICATOR_ONE(i1), .ALARM_INDICATOR_TWO(i2), .SAMPLE_TICK(tick));
    task conclude;
        $display("tests %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge CLK) begin
        cyc = cyc + 1;
        if (cyc > 20000) begin
            err_count = err_count + 1;
            conclude();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("Error t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer, released at the edge that samples ready
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge CLK);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge CLK);
        penable <= 1'b1;
        do @(posedge CLK); while (prdy !== 1'b1);
        rd = prd;
        rerr = perr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr16(input logic [11:0] a, input logic signed [15:0] v);
        apb(1'b1, a, {{16{v[15]}}, v});
    endtask
    task wait_tick;
        do @(negedge CLK); while (tick !== 1'b1);
    endtask
    task run(input logic [2:0] f1, input logic [2:0] f2, input logic signed [15:0] s1, input logic signed [15:0] d1,
             input logic signed [15:0] s2, input logic signed [15:0] d2, input logic signed [15:0] v,
             input logic [2:0] flt, input logic e1, input logic e2);
        apb(1'b1, `PAC_CTRL_OFS, {25'h0, f2, 1'b0, f1});
        wr16(`PAC_SP1_OFS, s1);
        wr16(`PAC_DEV1_OFS, d1);
        wr16(`PAC_SP2_OFS, s2);
        wr16(`PAC_DEV2_OFS, d2);
        want_value <= v;
        want_fault <= flt;
        wait_tick();
        wait_tick();
        chk({28'h0, i2, i1, r2, r1}, {28'h0, e2, e1, e2, e1});
        apb(1'b0, `PAC_STAT_OFS, 32'h0);
        chk({30'h0, rd[1:0]}, {30'h0, e2, e1});
        chk({30'h0, rd[3:2]}, {30'h0, (v > 16'sd9999) || (v < -16'sd1999),
            (|flt) || (v > 16'sd9999) || (v < -16'sd1999)});
        apb(1'b0, `PAC_VALUE_OFS, 32'h0);
        chk(rd, (v > 16'sd9999) ? 32'h0000270F :
            ((v < -16'sd1999) ? 32'hFFFFF831 : {{16{v[15]}}, v}));
        $display("test done f1 %0d f2 %0d value %0d", f1, f2, v);
    endtask
    initial begin
        repeat (10) @(posedge CLK);
        RESET <= 1'b0;
        apb(1'b0, `PAC_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, `PAC_ID_OFS, 32'h0);
        chk(rd, ID_EXP);
        chk({31'h0, rerr}, 32'h0);
        apb(1'b0, 12'h040, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        apb(1'b1, `PAC_CTRL_OFS, 32'h7);
        apb(1'b0, `PAC_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        wr16(`PAC_SP1_OFS, 16'sd12000);
        apb(1'b0, `PAC_SP1_OFS, 32'h0);
        chk(rd, 32'h0000270F);
        wr16(`PAC_SP1_OFS, -16'sd3000);
        apb(1'b0, `PAC_SP1_OFS, 32'h0);
        chk(rd, 32'hFFFFF831);
        $display("register tests done");
        run(`PAC_FN_OFF, `PAC_FN_SENSOR, 100, 0, 100, 0, 50, 3'h1, 0, 1);
        run(`PAC_FN_SENSOR, `PAC_FN_LOW, 100, 0, 100, 0, 50, 3'h2, 1, 0);
        run(`PAC_FN_SENSOR, `PAC_FN_SENSOR, 0, 0, 0, 0, 0, 3'h4, 1, 1);
        run(`PAC_FN_SENSOR, `PAC_FN_SENSOR, 0, 0, 0, 0, 0, 3'h0, 0, 0);
        run(`PAC_FN_SENSOR, `PAC_FN_OFF, 0, 0, 0, 0, 10000, 3'h0, 1, 0);
        run(`PAC_FN_LOW, `PAC_FN_HIGH, 100, 0, 100, 0, 99, 3'h0, 1, 0);
        run(`PAC_FN_LOW, `PAC_FN_HIGH, 100, 0, 100, 0, 100, 3'h0, 0, 0);
        run(`PAC_FN_LOW, `PAC_FN_HIGH, 100, 0, 100, 0, 101, 3'h0, 0, 1);
        run(`PAC_FN_LOW, `PAC_FN_HIGH, -1998, 0, 9998, 0, -1999, 3'h0, 1, 0);
        run(`PAC_FN_DIFF_LOW, `PAC_FN_DIFF_HIGH, 100, 10, 100, 10, 89, 3'h0, 1, 0);
        run(`PAC_FN_DIFF_LOW, `PAC_FN_DIFF_HIGH, 100, 10, 100, 10, 90, 3'h0, 0, 0);
        run(`PAC_FN_DIFF_LOW, `PAC_FN_DIFF_HIGH, 100, 10, 100, 10, 110, 3'h0, 0, 0);
        run(`PAC_FN_DIFF_LOW, `PAC_FN_DIFF_HIGH, 100, 10, 100, 10, 111, 3'h0, 0, 1);
        run(`PAC_FN_DIFF_LOW, `PAC_FN_DIFF_HIGH, 100, -10, 100, -10, 105, 3'h0, 1, 1);
        run(`PAC_FN_BAND, `PAC_FN_BAND, 100, 10, 100, -10, 100, 3'h0, 0, 1);
        run(`PAC_FN_BAND, `PAC_FN_BAND, 100, 10, 100, -10, 111, 3'h0, 1, 0);
        run(`PAC_FN_BAND, `PAC_FN_BAND, 100, 10, 100, -10, 90, 3'h0, 0, 0);
        conclude();
    end
endmodule // tb_pac_top
